// ---- hdl/odc_pkg.sv ----
`default_nettype none
package odc_pkg;
  localparam int ODC_NUM_OUT = 12;
  localparam int ODC_ADDR_W = 12;

  // byte addresses of the register words
  localparam logic [11:0] ODC_OFF_CTRL = 12'h000;
  localparam logic [11:0] ODC_OFF_MODE = 12'h004;
  localparam logic [11:0] ODC_OFF_STAT = 12'h008;

  // output control word layout
  localparam int ODC_GOE_BIT = 12;
  localparam int ODC_OFF_LSB = 0;
  localparam int ODC_OFF_MSB = 11;
  localparam int ODC_RSV_LSB = 13;
  localparam int ODC_RSV_MSB = 15;

  // mode/config word layout
  localparam int ODC_DIFF_LSB = 0;
  localparam int ODC_DRV_RST_BIT = 16;

  // reset values
  localparam logic ODC_GOE_RST = 1'h1;
  localparam logic [11:0] ODC_OFF_RST = 12'h000;
  localparam logic [11:0] ODC_DIFF_RST = 12'hfff;
  localparam logic ODC_DRV_RST_RST = 1'h0;

  typedef struct packed {
    logic [11:0] true_en;
    logic [11:0] comp_en;
  } odc_drv_t;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [ODC_ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } odc_apb_req_t;
endpackage
`default_nettype wire

// ---- hdl/odc_apb_slave.sv ----
`default_nettype none
module odc_apb_slave
  import odc_pkg::*;
(
  // apb request
  input wire odc_apb_req_t req,
  // decoded access
  output logic wr_ctrl,
  output logic wr_mode,
  output logic rd_hit,
  output logic [1:0] rd_sel
);
  // zero wait state: access phase completes in its first cycle
  wire access = req.sel && req.enable;
  wire hit_ctrl = req.addr == ODC_OFF_CTRL;
  wire hit_mode = req.addr == ODC_OFF_MODE;
  wire hit_stat = req.addr == ODC_OFF_STAT;
  assign wr_ctrl = access && req.write && hit_ctrl;
  assign wr_mode = access && req.write && hit_mode;
  assign rd_hit = hit_ctrl || hit_mode || hit_stat;
  assign rd_sel = hit_ctrl ? 2'h0 : (hit_mode ? 2'h1 : 2'h2);
endmodule
`default_nettype wire

// ---- hdl/odc_drv_gate.sv ----
`default_nettype none
module odc_drv_gate
  import odc_pkg::*;
(
  // controls
  input wire logic goe,
  input wire logic drv_rst,
  input wire logic [ODC_NUM_OUT-1:0] off,
  input wire logic [ODC_NUM_OUT-1:0] diff,
  input wire logic [ODC_NUM_OUT-1:0] ext_off,
  // driver enables
  output odc_drv_t nxt_drv
);
  genvar i;
  generate
    for (i = 0; i < ODC_NUM_OUT; i++) begin : g_out
      wire kill = !goe || drv_rst || off[i] || ext_off[i];
      // true driver serves both modes; complement only exists in diff
      assign nxt_drv.true_en[i] = !kill;
      assign nxt_drv.comp_en[i] = !kill && diff[i];
    end
  endgenerate
endmodule
`default_nettype wire

// ---- hdl/odc_out_ctrl.sv ----
`default_nettype none
// How it works
// - bit 12 is a read/write global output enable, reset to one
// - bits 11 to 3 are read/write driver disables, reset to zero
// - differential output disabled: true and complement drivers both off
// - single-ended output disabled: its one driver off
// - other disable sources OR with the bit; zero enables only if none
// - bits 2 to 0 disable outputs 2 to 0 the same way
// - a driver reset control forces every driver off
module odc_out_ctrl
  import odc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ODC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // other disable sources, one per output
  input wire logic [ODC_NUM_OUT-1:0] ext_off,
  // driver enables
  output logic [ODC_NUM_OUT-1:0] clk_out_true,
  output logic [ODC_NUM_OUT-1:0] clk_out_comp
);
  logic goe_ff;
  logic [ODC_NUM_OUT-1:0] driver_off_ff;
  logic [ODC_NUM_OUT-1:0] diff_ff;
  logic drv_rst_ff;
  odc_drv_t drv_ff;
  odc_drv_t nxt_drv;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic pready_ff;
  logic wr_ctrl;
  logic wr_mode;
  logic rd_hit;
  logic [1:0] rd_sel;
  odc_apb_req_t req;

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr,
                 wdata: pwdata};

  odc_apb_slave u_slave (
    .req(req),
    .wr_ctrl(wr_ctrl),
    .wr_mode(wr_mode),
    .rd_hit(rd_hit),
    .rd_sel(rd_sel)
  );

  odc_drv_gate u_gate (
    .goe(goe_ff),
    .drv_rst(drv_rst_ff),
    .off(driver_off_ff),
    .diff(diff_ff),
    .ext_off(ext_off),
    .nxt_drv(nxt_drv)
  );

  // byte lanes: low lane holds disables 7:0, second lane 11:8 and goe
  wire lane0 = pstrb[0];
  wire lane1 = pstrb[1];
  wire lane2 = pstrb[2];

  wire [11:0] nxt_off = {
    lane1 ? pwdata[ODC_OFF_MSB:8] : driver_off_ff[11:8],
    lane0 ? pwdata[7:ODC_OFF_LSB] : driver_off_ff[7:0]};
  wire nxt_goe = lane1 ? pwdata[ODC_GOE_BIT] : goe_ff;
  wire [11:0] nxt_diff = {
    lane1 ? pwdata[ODC_DIFF_LSB+11:ODC_DIFF_LSB+8] : diff_ff[11:8],
    lane0 ? pwdata[ODC_DIFF_LSB+7:ODC_DIFF_LSB] : diff_ff[7:0]};
  wire nxt_drv_rst = lane2 ? pwdata[ODC_DRV_RST_BIT] : drv_rst_ff;

  // reserved 15:13 read as zero
  wire [31:0] ctrl_word = {16'h0000, 3'h0, goe_ff, driver_off_ff};
  wire [31:0] mode_word = {15'h0000, drv_rst_ff, 4'h0, diff_ff};
  wire [31:0] stat_word = {8'h00, drv_ff.comp_en, drv_ff.true_en};
  wire [31:0] rd_word = (rd_sel == 2'h0) ? ctrl_word :
                        (rd_sel == 2'h1) ? mode_word : stat_word;
  wire setup = psel && !penable;
  wire [31:0] nxt_prdata = (setup && !pwrite && rd_hit) ? rd_word : 32'h0;
  // set in setup, so it stands only through the zero-wait access cycle
  wire nxt_pslverr = setup && !rd_hit;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      goe_ff <= ODC_GOE_RST;
      driver_off_ff <= ODC_OFF_RST;
    end else if (wr_ctrl) begin
      goe_ff <= nxt_goe;
      driver_off_ff <= nxt_off;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      diff_ff <= ODC_DIFF_RST;
      drv_rst_ff <= ODC_DRV_RST_RST;
    end else if (wr_mode) begin
      diff_ff <= nxt_diff;
      drv_rst_ff <= nxt_drv_rst;
    end
  end

  // read data latched in setup so the access phase answers at once
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      prdata_ff <= 32'h0;
      pslverr_ff <= 1'b0;
      pready_ff <= 1'b0;
      drv_ff <= '0;
    end else begin
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
      pready_ff <= 1'b1;
      drv_ff <= nxt_drv;
    end
  end

  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;
  assign pready = pready_ff;
  assign clk_out_true = drv_ff.true_en;
  assign clk_out_comp = drv_ff.comp_en;
endmodule
`default_nettype wire

// ---- testbench/odc_out_ctrl_sva.sv ----
`default_nettype none
module odc_out_ctrl_sva
  import odc_pkg::*;
(
  // bus
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ODC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // drivers
  input wire logic [ODC_NUM_OUT-1:0] ext_off,
  input wire logic [ODC_NUM_OUT-1:0] clk_out_true,
  input wire logic [ODC_NUM_OUT-1:0] clk_out_comp
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire acc = psel && penable;
  sequence s_wc;
    acc && pwrite && paddr == ODC_OFF_CTRL && pstrb[1:0] == 2'h3;
  endsequence
  sequence s_wm;
    acc && pwrite && paddr == ODC_OFF_MODE && pstrb[2:0] == 3'h7;
  endsequence
  a_goe_off: assert property (
    s_wc ##0 !pwdata[12] |=> ##1 !clk_out_true) else $error("goe ignored");
  a_dis_bits: assert property (
    s_wc |=> ##1 !(clk_out_true & $past(pwdata[11:0], 2))) else $error("dis");
  a_comp_pair: assert property (
    !(clk_out_comp & ~clk_out_true)) else $error("comp without true");
  a_cmos_off: assert property (
    s_wm ##0 !pwdata[11:0] |=> ##1 !clk_out_comp) else $error("cmos comp");
  a_ext_or: assert property (
    !(clk_out_true & $past(ext_off))) else $error("ext_off ignored");
  a_rst_val: assert property (
    $rose(rst_b) |=> clk_out_true == ~$past(ext_off)) else $error("reset");
  a_drv_rst: assert property (
    s_wm ##0 pwdata[16] |=> ##1 !(clk_out_true | clk_out_comp))
    else $error("driver reset ignored");
  a_rsv_zero: assert property (
    acc && !pwrite && paddr == ODC_OFF_CTRL |-> !prdata[15:13])
    else $error("reserved bits set");
endmodule
bind odc_out_ctrl odc_out_ctrl_sva i_sva(.clk_sys, .rst_b, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .ext_off,
  .clk_out_true, .clk_out_comp);
`default_nettype wire

// ---- testbench/tb.sv ----
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import odc_pkg::*;
  logic clk_sys = '0, rst_b = '0, psel = '0, penable = '0, pwrite = '0;
  logic [11:0] paddr = '0, ext_off = '0, t, c, clk_out_true, clk_out_comp;
  logic [31:0] pwdata = '0, r, d, ctl, mde, prdata;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, e;
  int bad_count = 0, checks = 0;
  odc_out_ctrl i_dut(.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .ext_off, .clk_out_true,
    .clk_out_comp);
  initial forever #4 clk_sys = ~clk_sys;
  task automatic print_verdict;
    $display("errors %0d checks %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one idle edge after each transfer keeps drivers single per time step
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] x);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= x;
    @(posedge clk_sys) penable <= 1'h1;
    do @(posedge clk_sys) n++; while (pready !== 1'h1 && n < 99);
    r = prdata;
    e = pslverr;
    if (n == 99) begin
      bad_count++;
      print_verdict();
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask
  initial begin
    void'($urandom(32'h823b));
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'h1;
    @(posedge clk_sys);
    ctl = 32'h1000;
    mde = 32'hfff;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_sys);
      t = (ctl[12] && !mde[16]) ? ~ctl[11:0] & ~ext_off : 12'h000;
      c = t & mde[11:0];
      `CHK(clk_out_true, t)
      `CHK(clk_out_comp, c)
      @(posedge clk_sys);
      apb(1'h0, ODC_OFF_CTRL, '0);
      `CHK({e, r}, {1'h0, ctl})
      apb(1'h0, ODC_OFF_MODE, '0);
      `CHK(r, mde)
      apb(1'h0, ODC_OFF_STAT, '0);
      `CHK(r, {8'h00, c, t})
      d = $urandom;
      apb(1'h1, ODC_OFF_CTRL, d);
      ctl = d & 32'h1fff;
      // change the other disables early so drivers settle before sampling
      ext_off <= 12'($urandom & $urandom);
      d = $urandom;
      if (i % 3 == 0) d[11:0] = 12'h000;
      d[16] = (i % 4 == 1);
      apb(1'h1, ODC_OFF_MODE, d);
      mde = d & 32'h10fff;
    end
    // low byte lane only: goe and disables 11:8 must keep their value
    pstrb <= 4'h1;
    apb(1'h1, ODC_OFF_CTRL, 32'hffffffff);
    ctl = (ctl & 32'h1f00) | 32'hff;
    apb(1'h0, ODC_OFF_CTRL, '0);
    `CHK(r, ctl)
    pstrb <= 4'hf;
    apb(1'h1, 12'h00c, $urandom);
    `CHK(e, 1'h1)
    apb(1'h0, 12'h00c, '0);
    `CHK({e, r}, {1'h1, 32'h0})
    print_verdict();
  end
endmodule
`default_nettype wire
